// [ffem_fault_flags.sv]
// Latched fault flags, two event mask registers and interrupt pulse request
`timescale 1ns/10ps
`default_nettype none
`include "ffem_params.svh"

// Summary of operation
// [R1] Fault flag register at 0x27, resets 0x00
// [R2] Reading fault flags clears all of them except a flag whose fault is set in the same cycle
// [R3] Bit 7 latches input under-voltage fault
// [R4] Bit 6 latches input over-voltage fault
// [R5] Bit 5 latches battery over-current fault
// [R6] Bit 4 latches battery over-voltage fault
// [R7] Bit 3 latches thermal shutdown fault
// [R8] Bit 1 latches driver supply fault; 2,0 zero
// [R9] First mask register at 0x28, resets 0x00
// [R10] Mask bit 7 gates one-shot conversion done
// [R11] Mask bit 6 gates input current regulation
// [R12] Mask bit 5 gates input voltage regulation
// [R13] Mask bit 3 gates host watchdog expiry
// [R14] Second mask register at 0x29, resets 0x00
// [R15] Mask bit 7 gates power-good toggle
// [R16] Mask bit 4 gates thermistor state change
// [R17] Mask bit 3 gates reverse-mode toggle
// [R18] Mask bit 1 gates switching-sync change
// [R19] Fault events gated by external fault mask
// [R20] Conversion done counts only in one-shot
// [R21] Watchdog flag set on status rising edge
// [R22] Flags latch regardless of mask bits
// [R23] One fixed pulse per new unmasked event; events during a pulse share one
// [R24] Register reset command clears mask bits
module ffem_fault_flags (
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	// Register port
	input  wire ffem_pkg::ffem_reg_req_s reg_req,
	output logic [7:0]                  reg_rdata,
	input  wire logic                   reg_reset_cmd,
	// Fault status levels from the analog side
	input  wire ffem_pkg::ffem_fault_s  fault_status,
	input  wire logic [7:0]             fault_mask,
	// Event pulses from core logic
	input  wire ffem_pkg::ffem_event_s  event_pulse,
	input  wire logic                   oneshot_mode,
	input  wire logic                   host_watchdog_state,
	output logic                        watchdog_flag_set,
	// Interrupt pin, open drain
	output logic                        int_out,
	output logic                        int_oe_n
);

	typedef struct packed {
		logic [5:0] sync_a;
		logic [5:0] sync_b;
		logic [5:0] prev;
		logic [7:0] flags;
		logic [7:0] mask_first;
		logic [7:0] mask_second;
		logic [7:0] rdata;
		logic       wd_prev;
		logic       wd_set;
		logic       pending;
	} ffem_state_s;

	ffem_state_s st;
	ffem_state_s next_st;

	logic [5:0] fault_vec;
	logic [5:0] fault_rise;
	logic [7:0] flag_set;
	logic [7:0] flag_new;
	logic [7:0] fault_gate;
	logic       wd_rise;
	logic       conv_done_ok;
	logic       first_hit;
	logic       second_hit;
	logic       fault_hit;
	logic       any_hit;
	logic       pulse_busy;
	logic       pulse_fire;

	assign fault_vec = {fault_status.input_uv, fault_status.input_ov,
		fault_status.batt_oc, fault_status.batt_ov,
		fault_status.thermal, fault_status.drv_supply};

	// Entering a fault is the edge of the synchronised status level
	assign fault_rise = st.sync_b & ~st.prev;

	always_comb begin
		flag_set = 8'h00;
		flag_set[`FFEM_BIT_INPUT_UV]   = fault_rise[5]; // R3
		flag_set[`FFEM_BIT_INPUT_OV]   = fault_rise[4]; // R4
		flag_set[`FFEM_BIT_BATT_OC]    = fault_rise[3]; // R5
		flag_set[`FFEM_BIT_BATT_OV]    = fault_rise[2]; // R6
		flag_set[`FFEM_BIT_THERMAL]    = fault_rise[1]; // R7
		flag_set[`FFEM_BIT_DRV_SUPPLY] = fault_rise[0]; // R8
	end

	// Only a flag going from clear to set counts as a new event
	assign flag_new = flag_set & ~st.flags & `FFEM_FLAG_IMPL; // R22
	assign fault_gate = flag_new & ~fault_mask; // R19
	assign fault_hit = |fault_gate;

	assign wd_rise = host_watchdog_state & ~st.wd_prev; // R21
	assign conv_done_ok = event_pulse.conv_done & oneshot_mode; // R20

	always_comb begin
		first_hit = 1'b0;
		if (conv_done_ok && !st.mask_first[`FFEM_BIT_CONV_DONE])
			first_hit = 1'b1; // R10
		if (event_pulse.in_cur_reg && !st.mask_first[`FFEM_BIT_IN_CUR_REG])
			first_hit = 1'b1; // R11
		if (event_pulse.in_volt_reg &&
			!st.mask_first[`FFEM_BIT_IN_VOLT_REG])
			first_hit = 1'b1; // R12
		if (wd_rise && !st.mask_first[`FFEM_BIT_WATCHDOG])
			first_hit = 1'b1; // R13
	end

	always_comb begin
		second_hit = 1'b0;
		if (event_pulse.power_good &&
			!st.mask_second[`FFEM_BIT_POWER_GOOD])
			second_hit = 1'b1; // R15
		if (event_pulse.thermistor &&
			!st.mask_second[`FFEM_BIT_THERMISTOR])
			second_hit = 1'b1; // R16
		if (event_pulse.reverse && !st.mask_second[`FFEM_BIT_REVERSE])
			second_hit = 1'b1; // R17
		if (event_pulse.sw_sync && !st.mask_second[`FFEM_BIT_SW_SYNC])
			second_hit = 1'b1; // R18
	end

	assign any_hit = fault_hit | first_hit | second_hit;

	// Events during a pulse merge into one follow-up pulse
	assign pulse_fire = (any_hit | st.pending) & ~pulse_busy; // R23

	always_comb begin
		next_st = st;
		next_st.sync_a = fault_vec;
		next_st.sync_b = st.sync_a;
		next_st.prev = st.sync_b;
		next_st.wd_prev = host_watchdog_state;
		next_st.wd_set = wd_rise; // R21
		next_st.pending = (st.pending | any_hit) & ~pulse_fire;

		// Set wins over the read clear so a same-cycle fault is kept
		if (reg_req.rd && reg_req.addr == `FFEM_ADDR_FAULT_FLAGS)
			next_st.flags = 8'h00; // R2
		next_st.flags = (next_st.flags | flag_set) & `FFEM_FLAG_IMPL; // R8

		if (reg_req.wr && reg_req.addr == `FFEM_ADDR_MASK_FIRST)
			next_st.mask_first = reg_req.wdata & `FFEM_MASK_FIRST_IMPL; // R9
		if (reg_req.wr && reg_req.addr == `FFEM_ADDR_MASK_SECOND)
			next_st.mask_second = reg_req.wdata & `FFEM_MASK_SECOND_IMPL; // R14
		if (reg_reset_cmd) begin
			next_st.mask_first  = `FFEM_RST_MASK_FIRST; // R24
			next_st.mask_second = `FFEM_RST_MASK_SECOND; // R24
		end

		if (reg_req.rd) begin
			unique case (reg_req.addr)
				`FFEM_ADDR_FAULT_FLAGS:
					next_st.rdata = st.flags; // R1
				`FFEM_ADDR_MASK_FIRST:
					next_st.rdata = st.mask_first;
				`FFEM_ADDR_MASK_SECOND:
					next_st.rdata = st.mask_second;
				default:
					next_st.rdata = `FFEM_READ_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st.sync_a      <= 6'h00;
			st.sync_b      <= 6'h00;
			st.prev        <= 6'h00;
			st.flags       <= `FFEM_RST_FAULT_FLAGS; // R1
			st.mask_first  <= `FFEM_RST_MASK_FIRST; // R9
			st.mask_second <= `FFEM_RST_MASK_SECOND; // R14
			st.rdata       <= 8'h00;
			st.wd_prev     <= 1'b0;
			st.wd_set      <= 1'b0;
			st.pending     <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	ffem_int_pulse u_pulse (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.fire     (pulse_fire),
		.busy     (pulse_busy),
		.int_oe_n (int_oe_n)
	);

	// Open drain: the pin is only ever pulled low
	assign int_out           = 1'b0;
	assign reg_rdata         = st.rdata;
	assign watchdog_flag_set = st.wd_set;

endmodule
`default_nettype wire

// [ffem_params.svh]
// Offsets, field positions, reset values and timing counts of the fault flag block
`ifndef FFEM_PARAMS_SVH
`define FFEM_PARAMS_SVH

`define FFEM_ADDR_FAULT_FLAGS   8'h27
`define FFEM_ADDR_MASK_FIRST    8'h28
`define FFEM_ADDR_MASK_SECOND   8'h29

`define FFEM_RST_FAULT_FLAGS    8'h00
`define FFEM_RST_MASK_FIRST     8'h00
`define FFEM_RST_MASK_SECOND    8'h00
`define FFEM_READ_UNMAPPED      8'h00

`define FFEM_BIT_INPUT_UV       7
`define FFEM_BIT_INPUT_OV       6
`define FFEM_BIT_BATT_OC        5
`define FFEM_BIT_BATT_OV        4
`define FFEM_BIT_THERMAL        3
`define FFEM_BIT_DRV_SUPPLY     1

`define FFEM_BIT_CONV_DONE      7
`define FFEM_BIT_IN_CUR_REG     6
`define FFEM_BIT_IN_VOLT_REG    5
`define FFEM_BIT_WATCHDOG       3
`define FFEM_BIT_FIRST_SPARE    0

`define FFEM_BIT_POWER_GOOD     7
`define FFEM_BIT_THERMISTOR     4
`define FFEM_BIT_REVERSE        3
`define FFEM_BIT_SW_SYNC        1

`define FFEM_FLAG_IMPL          8'hFA
`define FFEM_MASK_FIRST_IMPL    8'hE9
`define FFEM_MASK_SECOND_IMPL   8'h9A

`define FFEM_CLK_HZ             10000000
`define FFEM_INT_PULSE_NS       256000
`define FFEM_INT_PULSE_CYC      ((`FFEM_INT_PULSE_NS * (`FFEM_CLK_HZ / 1000000)) / 1000)
`define FFEM_CNT_W              12

`endif

// [ffem_pkg.sv]
// Types shared by the fault flag and event mask block
package ffem_pkg;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ffem_reg_req_s;

	typedef struct packed {
		logic input_uv;
		logic input_ov;
		logic batt_oc;
		logic batt_ov;
		logic thermal;
		logic drv_supply;
	} ffem_fault_s;

	typedef struct packed {
		logic conv_done;
		logic in_cur_reg;
		logic in_volt_reg;
		logic power_good;
		logic thermistor;
		logic reverse;
		logic sw_sync;
	} ffem_event_s;

	typedef enum logic [0:0] {
		FFEM_IDLE  = 1'b0,
		FFEM_PULSE = 1'b1
	} ffem_pulse_e;

endpackage

// [ffem_int_pulse.sv]
// Fixed-width active-low pulse driver for the open-drain interrupt pin
`timescale 1ns/10ps
`default_nettype none
`include "ffem_params.svh"

module ffem_int_pulse (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// Request
	input  wire logic fire,
	output logic      busy,
	// Pin
	output logic      int_oe_n
);

	typedef struct packed {
		ffem_pkg::ffem_pulse_e   state;
		logic [`FFEM_CNT_W-1:0] count;
		logic                    oe_n;
	} ffem_pulse_s;

	localparam logic [`FFEM_CNT_W-1:0] PULSE_LAST =
		`FFEM_CNT_W'(`FFEM_INT_PULSE_CYC - 1);

	ffem_pulse_s st;
	ffem_pulse_s next_st;

	always_comb begin
		next_st = st;
		unique case (st.state)
			ffem_pkg::FFEM_IDLE: begin
				if (fire) begin
					next_st.state = ffem_pkg::FFEM_PULSE;
					next_st.count = '0;
					next_st.oe_n  = 1'b0;
				end
			end
			ffem_pkg::FFEM_PULSE: begin
				if (st.count == PULSE_LAST) begin
					next_st.state = ffem_pkg::FFEM_IDLE;
					next_st.oe_n  = 1'b1;
				end else begin
					next_st.count = st.count + `FFEM_CNT_W'(1);
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st.state <= ffem_pkg::FFEM_IDLE;
			st.count <= '0;
			st.oe_n  <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign busy     = (st.state == ffem_pkg::FFEM_PULSE);
	assign int_oe_n = st.oe_n;

endmodule
`default_nettype wire

// [ffem_checker.sv]
// Port-level assertions for the fault flag block
`timescale 1ns/10ps
`default_nettype none
module ffem_checker (
	// Clock and reset
	input wire logic                    mclk,
	input wire logic                    rst_n,
	// Register port
	input wire ffem_pkg::ffem_reg_req_s reg_req,
	input wire logic [7:0]              reg_rdata,
	input wire logic                    reg_reset_cmd,
	// Events and pin
	input wire ffem_pkg::ffem_fault_s   fault_status,
	input wire logic                    host_watchdog_state,
	input wire logic                    watchdog_flag_set,
	input wire logic                    int_out,
	input wire logic                    int_oe_n
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic [11:0] low_cyc;
	logic        rd27;
	assign rd27 = reg_req.rd && reg_req.addr == 8'h27;
	always_ff @(posedge mclk) begin
		if (!rst_n) low_cyc <= 12'h000;
		else low_cyc <= int_oe_n ? 12'h000 : low_cyc + 12'h001;
	end
	a_unmapped_read: assert property (reg_req.rd && reg_req.addr > 8'h29
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_reserved_zero: assert property (rd27
		|=> !reg_rdata[2] && !reg_rdata[0]) else $error("reserved flag set");
	a_mask_readback: assert property (reg_req.wr && reg_req.addr == 8'h28
		&& !reg_reset_cmd ##1 !reg_req.wr && !reg_reset_cmd
		##1 reg_req.rd && reg_req.addr == 8'h28
		&& !reg_req.wr && !reg_reset_cmd
		|=> reg_rdata == ($past(reg_req.wdata, 3) & 8'hE9))
		else $error("mask readback wrong");
	a_fault_latch: assert property ($rose(fault_status.thermal)
		##1 (!rd27)[*5] ##1 rd27 |=> reg_rdata[3])
		else $error("fault not latched");
	a_watchdog_flag: assert property ($rose(host_watchdog_state)
		|=> watchdog_flag_set ##1 !watchdog_flag_set)
		else $error("watchdog flag pulse wrong");
	a_pulse_width: assert property ($rose(int_oe_n) |-> low_cyc == 12'd2560)
		else $error("interrupt pulse width wrong");
	a_pin_data_low: assert property (int_out == 1'b0)
		else $error("open drain data not low");
	a_unmasked_wd: assert property (reg_reset_cmd && !reg_req.wr
		##1 $rose(host_watchdog_state) && $past(int_oe_n) && int_oe_n
		&& !reg_req.wr |-> ##[1:2] !int_oe_n)
		else $error("watchdog pulse missing");
	cover property ($fell(int_oe_n));
	cover property (watchdog_flag_set);
	cover property (rd27 ##1 reg_rdata != 8'h00);
endmodule
bind ffem_fault_flags ffem_checker ffem_checker_i (.mclk, .rst_n, .reg_req,
	.reg_rdata, .reg_reset_cmd, .fault_status, .host_watchdog_state,
	.watchdog_flag_set, .int_out, .int_oe_n);
`default_nettype wire

// [ffem_host.sv]
// Host side: open-drain interrupt line and pulse counter
`timescale 1ns/10ps
`default_nettype none
module ffem_host (
	// Pin
	input  wire logic int_out,
	input  wire logic int_oe_n,
	// Observation
	output var int    n_pulses
);
	// Pull-up holds the line high whenever the device lets go
	wire int_line = int_oe_n ? 1'b1 : int_out;
	initial n_pulses = 0;
	always @(negedge int_line) n_pulses++;
endmodule
`default_nettype wire

// [ffem_fault_flags_tb_top.sv]
// Self-checking bench for the fault flag and event mask block
`timescale 1ns/10ps
`default_nettype none
module ffem_fault_flags_tb_top;
	logic                  mclk, rst_n, rcmd, oneshot, wds;
	ffem_pkg::ffem_reg_req_s req;
	ffem_pkg::ffem_fault_s fs;
	ffem_pkg::ffem_event_s ev;
	logic [7:0]            fmask, d;
	wire logic [7:0]       rdata;
	wire logic             int_out, oe_n, wfs;
	int                    failures, n_compared, npl, exp_p, i;
	ffem_fault_flags ffem_fault_flags_i (.mclk(mclk), .rst_n(rst_n),
		.reg_req(req), .reg_rdata(rdata), .reg_reset_cmd(rcmd),
		.fault_status(fs), .fault_mask(fmask), .event_pulse(ev),
		.oneshot_mode(oneshot), .host_watchdog_state(wds),
		.watchdog_flag_set(wfs), .int_out(int_out), .int_oe_n(oe_n));
	ffem_host ffem_host_i (.int_out(int_out), .int_oe_n(oe_n), .n_pulses(npl));
	task automatic chk(input logic [7:0] g, e);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wait_c(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(negedge mclk);
		req.rd = 1'b1;
		req.addr = a;
		@(negedge mclk);
		req.rd = 1'b0;
		chk(rdata, e);
	endtask
	task automatic wr(input logic [7:0] a, w);
		@(negedge mclk);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = w;
		@(negedge mclk);
		req.wr = 1'b0;
	endtask
	// Long enough for sync latency plus one full pulse
	task automatic pulses();
		wait_c(2600);
		chk(8'(npl), 8'(exp_p));
	endtask
	task automatic conclude();
		if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		#4000000;
		failures++;
		conclude();
	end
	initial begin
		{rst_n, rcmd, oneshot, wds} = 4'h0;
		req = '0;
		fs = '0;
		ev = '0;
		fmask = 8'hFF;
		failures = 0;
		n_compared = 0;
		exp_p = 0;
		void'($urandom(67));
		wait_c(3);
		rst_n = 1'b1;
		rd(8'h27, 8'h00);
		rd(8'h28, 8'h00);
		rd(8'h29, 8'h00);
		rd(8'h2B, 8'h00);
		wr(8'h27, 8'hFF);
		rd(8'h27, 8'h00);
		repeat (4) begin
			d = 8'($urandom);
			wr(8'h28, d);
			rd(8'h28, d & 8'hE9);
			wr(8'h29, ~d);
			rd(8'h29, ~d & 8'h9A);
		end
		for (i = 0; i < 6; i++) begin
			fs = 6'(1 << i);
			wait_c(5);
			fs = '0;
			d = (i == 0) ? 8'h02 : 8'(8'h04 << i);
			rd(8'h27, d);
			rd(8'h27, 8'h00);
		end
		pulses();
		fmask = 8'h00;
		fs.thermal = 1'b1;
		exp_p++;
		pulses();
		fs = '0;
		rd(8'h27, 8'h08);
		wr(8'h28, 8'hFF);
		wr(8'h29, 8'hFF);
		oneshot = 1'b1;
		for (i = 0; i < 7; i++) begin
			ev = 7'(1 << i);
			wait_c(1);
			ev = '0;
			wait_c(3);
		end
		wds = 1'b1;
		wait_c(3);
		wds = 1'b0;
		pulses();
		rcmd = 1'b1;
		wait_c(1);
		rcmd = 1'b0;
		wds = 1'b1;
		wait_c(1);
		chk({7'h00, wfs}, 8'h01);
		wait_c(1);
		chk({7'h00, wfs}, 8'h00);
		exp_p++;
		pulses();
		wds = 1'b0;
		rd(8'h28, 8'h00);
		rd(8'h29, 8'h00);
		for (i = 0; i < 7; i++) begin
			ev = 7'(1 << i);
			wait_c(1);
			ev = '0;
			exp_p++;
			pulses();
		end
		oneshot = 1'b0;
		ev.conv_done = 1'b1;
		wait_c(1);
		ev = '0;
		pulses();
		conclude();
	end
endmodule
`default_nettype wire
